// ### src/svm_pkg.sv
package svm_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int          CHAN_N    = 2;
   localparam int          ADDR_W    = 16;
   localparam int          DATA_W    = 32;

   // ----------------------------------------------------------------
   // register map: printed offsets are indices, bus address is 4x
   // ----------------------------------------------------------------
   localparam logic [15:0] FLAG_IDX  = 16'h0FC6;
   localparam logic [15:0] CTRL_IDX  = 16'h0FC7;
   localparam logic [15:0] FLAG_ADDR = {FLAG_IDX[13:0], 2'h0};
   localparam logic [15:0] CTRL_ADDR = {CTRL_IDX[13:0], 2'h0};

   // monitor_enable_action_ctrl fields, per channel at stride 2
   localparam int          CTRL_STRIDE  = 2;
   localparam int          CTRL_ON_POS  = 0;
   localparam int          CTRL_ACT_POS = 1;
   localparam int          CTRL_SPARE_LSB = 4;
   localparam int          CTRL_W       = 6;
   localparam logic [5:0]  CTRL_RST     = 6'h00;

   // monitor_level_flag_reg fields, per channel at stride 4
   localparam int          FLAG_STRIDE   = 4;
   localparam int          FLAG_LVL_LSB  = 0;
   localparam int          FLAG_LIVE_POS = 2;
   localparam int          FLAG_STICKY_POS = 3;
   localparam logic [3:0]  LVL_RST       = 4'h8;

   // ----------------------------------------------------------------
   // bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic on;
      logic act;
      logic lowpower;
      logic clr_sticky;
   } svm_chan_ctl_t;

   typedef struct packed {
      logic sticky;
      logic live;
      logic irq;
      logic rst;
   } svm_chan_stat_t;

   // ----------------------------------------------------------------
   // state records
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CHAN_N-1:0] stage1;
      logic [CHAN_N-1:0] stage2;
   } svm_sync_st_t;

   localparam svm_sync_st_t SYNC_RST = '{stage1: 2'h0, stage2: 2'h0};

   typedef struct packed {
      logic below_d;
      logic on_d;
      logic pend_irq;
      logic pend_det;
      logic sticky;
      logic live;
      logic irq;
      logic rst;
   } svm_chan_st_t;

   localparam svm_chan_st_t CHAN_RST = '0;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              aw_full;
      logic              w_full;
      logic [15:0]       awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic [5:0]        ctrl;
      logic [3:0]        lvl;
      logic              irq;
      logic              rst;
   } svm_top_st_t;

endpackage

// ### src/svm_sync.sv
`timescale 1ns/1ns

module svm_sync (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [svm_pkg::CHAN_N-1:0] async_in,
   output logic      [svm_pkg::CHAN_N-1:0] sync_out
);
   import svm_pkg::*;

   svm_sync_st_t r;
   svm_sync_st_t next_r;

   // the first stage feeds only the second; nothing else looks at it
   always_comb begin
      next_r        = r;
      next_r.stage1 = async_in;
      next_r.stage2 = r.stage1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= SYNC_RST;
      end else begin
         r <= next_r;
      end
   end

   assign sync_out = r.stage2;

endmodule

// ### src/svm_chan.sv
`timescale 1ns/1ns

module svm_chan (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire logic                    below,
   input  svm_pkg::svm_chan_ctl_t       ctl,
   output svm_pkg::svm_chan_stat_t      stat
);
   import svm_pkg::*;

   svm_chan_st_t r;
   svm_chan_st_t next_r;
   logic         det;
   logic         req;

   always_comb begin
      next_r = r;
      // a live detection only counts while monitoring is on
      det = ctl.on & below;
      // either crossing, or switching on while already low
      req = ~ctl.act & ((ctl.on & (below != r.below_d)) | (det & ~r.on_d));
      next_r.below_d = below;
      next_r.on_d    = ctl.on;
      next_r.irq     = 1'b0;
      // reset request ignores low power: it must stand while low
      next_r.rst     = det & ctl.act;
      if (ctl.lowpower) begin
         // hold flags and requests until the chip is back awake
         next_r.pend_irq = r.pend_irq | req;
         next_r.pend_det = r.pend_det | det;
         next_r.sticky   = r.sticky & ~ctl.clr_sticky;
      end else begin
         next_r.irq      = req | r.pend_irq;
         next_r.pend_irq = 1'b0;
         next_r.pend_det = 1'b0;
         // live and sticky move on the same edge, so no skew at all
         next_r.live     = det;
         // set wins over a coincident clear
         next_r.sticky   = (r.sticky & ~ctl.clr_sticky) | det | r.pend_det;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= CHAN_RST;
      end else begin
         r <= next_r;
      end
   end

   assign stat.sticky = r.sticky;
   assign stat.live   = r.live;
   assign stat.irq    = r.irq;
   assign stat.rst    = r.rst;

endmodule

// ### src/svm_ctrl.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns

// Function
// - control bits 7:6 read zero; bit map
// - control cleared only by power-on/external reset
// - enable bit turns channel on, resets zero
// - enabling while low fires request at once
// - action bit: zero interrupt, one reset
// - interrupt action pulses on threshold crossings
// - low-power detections request after mode exit
// - reset held while supply stays low
// - sticky flag set on detection, kept
// - sticky cleared only by software zero-write; aresetn also clears it
// - live flag follows comparator, no latching
// - low-power detections update flags after wake
// - live and sticky set on the same edge, no skew
// - armed reset channel re-fires after reset
// - detection beats coincident sticky clear
// - writing one to sticky does nothing
module svm_ctrl (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [svm_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [svm_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [svm_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [svm_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic [svm_pkg::CHAN_N-1:0]    supply_below,
   input  wire logic                          lowpower_active,
   output logic [svm_pkg::CHAN_N-1:0]         chan_monitor_on,
   output logic [2*svm_pkg::CHAN_N-1:0]       chan_threshold_sel,
   output logic                               supply_low_irq,
   output logic                               monitor_reset
);
   import svm_pkg::*;

   // ----------------------------------------------------------------
   // decoding shared by the read and write paths
   // ----------------------------------------------------------------
   function automatic logic reg_hit(input logic [15:0] addr,
                                    input logic [15:0] base);
      reg_hit = (addr[15:2] == base[15:2]);
   endfunction

   svm_top_st_t                r;
   svm_top_st_t                next_r;
   logic [CHAN_N-1:0]          below_sync;
   svm_chan_ctl_t              ctl  [CHAN_N];
   svm_chan_stat_t             stat [CHAN_N];
   logic [CHAN_N-1:0]          clr;
   logic [CHAN_N-1:0]          any_irq;
   logic [CHAN_N-1:0]          any_rst;
   logic                       do_wr;
   logic                       wr_ctrl;
   logic                       wr_flag;
   logic [7:0]                 flag_view;

   // ----------------------------------------------------------------
   // comparator inputs
   // ----------------------------------------------------------------
   svm_sync u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (supply_below),
      .sync_out (below_sync)
   );

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   for (genvar i = 0; i < CHAN_N; i++) begin : g_chan
      assign ctl[i].on         = r.ctrl[CTRL_STRIDE*i+CTRL_ON_POS];
      assign ctl[i].act        = r.ctrl[CTRL_STRIDE*i+CTRL_ACT_POS];
      assign ctl[i].lowpower   = lowpower_active;
      assign ctl[i].clr_sticky = clr[i];
      assign any_irq[i]        = stat[i].irq;
      assign any_rst[i]        = stat[i].rst;

      svm_chan u_chan (
         .aclk    (aclk),
         .aresetn (aresetn),
         .below   (below_sync[i]),
         .ctl     (ctl[i]),
         .stat    (stat[i])
      );
   end

   // ----------------------------------------------------------------
   // read view of the level and flag register
   // ----------------------------------------------------------------
   always_comb begin
      flag_view = '0;
      for (int i = 0; i < CHAN_N; i++) begin
         flag_view[FLAG_STRIDE*i+FLAG_LVL_LSB +: 2] = r.lvl[2*i +: 2];
         flag_view[FLAG_STRIDE*i+FLAG_LIVE_POS]     = stat[i].live;
         flag_view[FLAG_STRIDE*i+FLAG_STICKY_POS]   = stat[i].sticky;
      end
   end

   // ----------------------------------------------------------------
   // write strobes
   // ----------------------------------------------------------------
   always_comb begin
      do_wr   = r.aw_full & r.w_full & ~r.bvalid;
      wr_ctrl = do_wr & r.wstrb[0] & reg_hit(r.awaddr, CTRL_ADDR);
      wr_flag = do_wr & r.wstrb[0] & reg_hit(r.awaddr, FLAG_ADDR);
      for (int i = 0; i < CHAN_N; i++) begin
         // only a written zero clears; a one leaves the flag alone
         clr[i] = wr_flag & ~r.wdata[FLAG_STRIDE*i+FLAG_STICKY_POS];
      end
   end

   // ----------------------------------------------------------------
   // next state: bus slave, registers, outputs
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;

      if (s_axi_awvalid && r.awready) begin
         next_r.awready = 1'b0;
         next_r.aw_full = 1'b1;
         next_r.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready) begin
         next_r.wready  = 1'b0;
         next_r.w_full  = 1'b1;
         next_r.wdata   = s_axi_wdata;
         next_r.wstrb   = s_axi_wstrb;
      end

      if (do_wr) begin
         next_r.aw_full = 1'b0;
         next_r.w_full  = 1'b0;
         next_r.bvalid  = 1'b1;
         if (reg_hit(r.awaddr, CTRL_ADDR) || reg_hit(r.awaddr, FLAG_ADDR)) begin
            next_r.bresp = RESP_OKAY;
         end else begin
            next_r.bresp = RESP_SLVERR;
         end
      end
      if (wr_ctrl) begin
         // bits 5:4 are kept as written so software sees its zeros back
         next_r.ctrl = r.wdata[CTRL_W-1:0];
      end
      if (wr_flag) begin
         for (int i = 0; i < CHAN_N; i++) begin
            next_r.lvl[2*i +: 2] = r.wdata[FLAG_STRIDE*i+FLAG_LVL_LSB +: 2];
         end
      end

      // one write in flight: take the next only after the answer
      if (r.bvalid && s_axi_bready) begin
         next_r.bvalid  = 1'b0;
         next_r.awready = 1'b1;
         next_r.wready  = 1'b1;
      end

      if (s_axi_arvalid && r.arready) begin
         next_r.arready = 1'b0;
         next_r.rvalid  = 1'b1;
         next_r.rdata   = '0;
         next_r.rresp   = RESP_OKAY;
         if (reg_hit(s_axi_araddr, CTRL_ADDR)) begin
            // top two bits always read back zero
            next_r.rdata[CTRL_W-1:0] = r.ctrl;
         end else if (reg_hit(s_axi_araddr, FLAG_ADDR)) begin
            next_r.rdata[7:0] = flag_view;
         end else begin
            next_r.rresp = RESP_SLVERR;
         end
      end
      if (r.rvalid && s_axi_rready) begin
         next_r.rvalid  = 1'b0;
         next_r.arready = 1'b1;
      end

      next_r.irq = |any_irq;
      // a monitor reset never reaches aresetn, so control survives it
      next_r.rst = |any_rst;
   end

   // ----------------------------------------------------------------
   // state register: only power-on or external reset clears it
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r         <= '0;
         r.awready <= 1'b1;
         r.wready  <= 1'b1;
         r.arready <= 1'b1;
         r.ctrl    <= CTRL_RST;
         r.lvl     <= LVL_RST;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign s_axi_awready = r.awready;
   assign s_axi_wready  = r.wready;
   assign s_axi_bvalid  = r.bvalid;
   assign s_axi_bresp   = r.bresp;
   assign s_axi_arready = r.arready;
   assign s_axi_rvalid  = r.rvalid;
   assign s_axi_rdata   = r.rdata;
   assign s_axi_rresp   = r.rresp;
   assign supply_low_irq = r.irq;
   assign monitor_reset  = r.rst;
   assign chan_threshold_sel = r.lvl;

   always_comb begin
      for (int i = 0; i < CHAN_N; i++) begin
         chan_monitor_on[i] = r.ctrl[CTRL_STRIDE*i+CTRL_ON_POS];
      end
   end

endmodule

// ### tb/svm_checker.sv
`timescale 1ns/1ns
module svm_checker
   import svm_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [15:0] s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [1:0]  supply_below,
   input wire logic        lowpower_active,
   input wire logic [1:0]  chan_monitor_on,
   input wire logic [3:0]  chan_threshold_sel,
   input wire logic        supply_low_irq,
   input wire logic        monitor_reset
);
   logic [1:0] sb_d;
   logic       lp_d;
   logic [3:0] sb_age;
   logic [3:0] bv_age;
   logic [3:0] lp_age;
   logic       rd_ctrl;
   logic       rd_bad;

   // ----------
   // ages of the last cause seen; an output event needs a recent cause
   // ----------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sb_d    <= 2'h0;
         lp_d    <= 1'b0;
         sb_age  <= 4'h0;
         bv_age  <= 4'h0;
         lp_age  <= 4'h0;
         rd_ctrl <= 1'b0;
         rd_bad  <= 1'b0;
      end else begin
         sb_d   <= supply_below;
         lp_d   <= lowpower_active;
         sb_age <= (sb_d != supply_below) ? 4'h0 : sb_age + {3'h0, sb_age != 4'hF};
         bv_age <= s_axi_bvalid ? 4'h0 : bv_age + {3'h0, bv_age != 4'hF};
         lp_age <= (lp_d && !lowpower_active) ? 4'h0 : lp_age + {3'h0, lp_age != 4'hF};
         if (s_axi_arvalid && s_axi_arready) begin
            rd_ctrl <= s_axi_araddr[15:2] == CTRL_ADDR[15:2];
            rd_bad  <= s_axi_araddr[15:2] != CTRL_ADDR[15:2]
                       && s_axi_araddr[15:2] != FLAG_ADDR[15:2];
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_irq_cause;
      supply_low_irq |-> sb_age < 4'h8 || bv_age < 4'h8 || s_axi_bvalid || lp_age < 4'h8;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("request without a cause");
   property p_irq_sleep;
      lowpower_active [*5] |-> !supply_low_irq;
   endproperty
   a_irq_sleep: assert property (p_irq_sleep)
      else $error("request during low power");
   property p_rst_on;
      monitor_reset |-> |{chan_monitor_on, $past(chan_monitor_on), $past(chan_monitor_on, 2),
                          $past(chan_monitor_on, 3)};
   endproperty
   a_rst_on: assert property (p_rst_on)
      else $error("reset with no channel on");
   property p_rst_hold;
      $fell(monitor_reset) |-> sb_age < 4'h8 || bv_age < 4'h8 || s_axi_bvalid;
   endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("reset dropped without a cause");
   property p_cfg_stable;
      $changed({chan_monitor_on, chan_threshold_sel}) |-> s_axi_bvalid || bv_age < 4'h2;
   endproperty
   a_cfg_stable: assert property (p_cfg_stable)
      else $error("config changed without a write");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_awready ##1 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write answer late");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_ctrl_rd;
      s_axi_rvalid && rd_ctrl |-> s_axi_rdata[31:6] == 26'h0;
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd)
      else $error("control upper bits not zero");
   property p_bad_rd;
      s_axi_rvalid && rd_bad |-> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_bad_rd: assert property (p_bad_rd)
      else $error("unmapped read not refused");

   c_irq: cover property (supply_low_irq);
   c_rst: cover property (monitor_reset);
   c_wake: cover property ($fell(lowpower_active));
endmodule

bind svm_ctrl svm_checker chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .supply_below(supply_below), .lowpower_active(lowpower_active),
   .chan_monitor_on(chan_monitor_on), .chan_threshold_sel(chan_threshold_sel),
   .supply_low_irq(supply_low_irq), .monitor_reset(monitor_reset));

// ### tb/svm_supply_model.sv
`timescale 1ns/1ns
module svm_supply_model (
   input  wire logic [1:0] supply_cmd,
   output logic      [1:0] supply_below
);
   initial supply_below = 2'h0;
   // no hysteresis: output follows the supply, late by a clock-unrelated delay
   always @(supply_cmd) supply_below <= #3 supply_cmd;
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import svm_pkg::*;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [15:0] s_axi_awaddr, s_axi_araddr;
   logic [3:0]  chan_threshold_sel, lvl;
   logic [1:0]  s_axi_bresp, s_axi_rresp, supply_below, chan_monitor_on, supply_cmd;
   logic        aclk = 1'b0;
   logic        aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, lowpower_active, supply_low_irq, monitor_reset;
   int          err_count, checks_done, irq_n, n0;

   svm_supply_model cmp (.supply_cmd(supply_cmd), .supply_below(supply_below));
   svm_ctrl uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .supply_below(supply_below),
      .lowpower_active(lowpower_active), .chan_monitor_on(chan_monitor_on),
      .chan_threshold_sel(chan_threshold_sel), .supply_low_irq(supply_low_irq),
      .monitor_reset(monitor_reset));

   always #2 aclk = ~aclk;
   always @(posedge aclk) if (supply_low_irq === 1'b1) irq_n <= irq_n + 1;

   // ----------
   // helpers
   // ----------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] fx(input logic [3:0] l, input logic [1:0] lv, sk);
      return {24'h0, sk[1], lv[1], l[3:2], sk[0], lv[0], l[1:0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      s_axi_bready <= 1'b0;
      chk(32'({s_axi_bvalid, s_axi_bresp}), 32'({1'b1, er}), "write answer");
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] ex, input logic [1:0] er);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      s_axi_rready <= 1'b0;
      chk(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'b1, er}), "read answer");
      chk(s_axi_rdata, ex, "read data");
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------
   // watchdog: the sequence needs a few hundred cycles, this allows 25000
   // ----------
   initial begin
      #100000;
      err_count++;
      finish_test();
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h00;
      {s_axi_rready, lowpower_active, err_count, checks_done, irq_n} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, supply_cmd} = '0;
      seed = 32'h000011B1;
      cyc(6);
      aresetn <= 1'b1;
      rd(CTRL_ADDR, 32'h0, RESP_OKAY);
      rd(FLAG_ADDR, 32'h20, RESP_OKAY);
      chk(32'(chan_threshold_sel), 32'h8, "level reset");
      wr(16'h3F20, 32'hFF, RESP_SLVERR);
      rd(16'h3F20, 32'h0, RESP_SLVERR);
      // random settings, supply quiet; spare bits always written zero
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         lvl = {seed[5:4], seed[1:0]};
         wr(CTRL_ADDR, seed & 32'hFFFFFFCF, RESP_OKAY);
         rd(CTRL_ADDR, 32'(seed[3:0]), RESP_OKAY);
         chk(32'(chan_monitor_on), 32'({seed[2], seed[0]}), "enables");
         wr(FLAG_ADDR, seed, RESP_OKAY);
         rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
         chk(32'(chan_threshold_sel), 32'(lvl), "level");
      end
      chk(32'(irq_n), 32'h0, "quiet supply");
      wr(CTRL_ADDR, 32'h1, RESP_OKAY);
      supply_cmd <= 2'h1;
      cyc(10);
      chk(32'(irq_n), 32'h1, "falling crossing");
      rd(FLAG_ADDR, fx(lvl, 2'h1, 2'h1), RESP_OKAY);
      supply_cmd <= 2'h0;
      cyc(10);
      chk(32'(irq_n), 32'h2, "rising crossing");
      rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h1), RESP_OKAY);
      wr(CTRL_ADDR, 32'h0, RESP_OKAY);
      rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h1), RESP_OKAY);
      wr(FLAG_ADDR, fx(lvl, 2'h3, 2'h3), RESP_OKAY);
      rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h1), RESP_OKAY);
      wr(FLAG_ADDR, fx(lvl, 2'h3, 2'h0), RESP_OKAY);
      rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
      supply_cmd <= 2'h2;
      cyc(10);
      chk(32'(irq_n), 32'h2, "disabled channel");
      rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
      wr(CTRL_ADDR, 32'h4, RESP_OKAY);
      cyc(6);
      chk(32'(irq_n), 32'h3, "enable while low");
      rd(FLAG_ADDR, fx(lvl, 2'h2, 2'h2), RESP_OKAY);
      supply_cmd <= 2'h0;
      cyc(10);
      wr(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
      wr(CTRL_ADDR, 32'hC, RESP_OKAY);
      n0 = irq_n;
      supply_cmd <= 2'h2;
      cyc(30);
      chk(32'({monitor_reset, 6'(irq_n - n0)}), 32'h40, "reset action");
      rd(CTRL_ADDR, 32'hC, RESP_OKAY);
      supply_cmd <= 2'h0;
      cyc(10);
      chk(32'(monitor_reset), 32'h0, "supply back");
      supply_cmd <= 2'h2;
      cyc(10);
      chk(32'(monitor_reset), 32'h1, "falls again");
      supply_cmd <= 2'h0;
      wr(CTRL_ADDR, 32'h4, RESP_OKAY);
      wr(CTRL_ADDR, 32'h0, RESP_OKAY);
      wr(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
      wr(CTRL_ADDR, 32'h1, RESP_OKAY);
      cyc(10);
      n0 = irq_n;
      lowpower_active <= 1'b1;
      supply_cmd <= 2'h1;
      cyc(30);
      chk(32'(irq_n - n0), 32'h0, "held in low power");
      rd(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
      lowpower_active <= 1'b0;
      cyc(10);
      chk(32'(irq_n - n0), 32'h1, "after wake");
      rd(FLAG_ADDR, fx(lvl, 2'h1, 2'h1), RESP_OKAY);
      // supply still low: the zero-write meets a detection in the same cycle
      wr(FLAG_ADDR, fx(lvl, 2'h0, 2'h0), RESP_OKAY);
      rd(FLAG_ADDR, fx(lvl, 2'h1, 2'h1), RESP_OKAY);
      aresetn <= 1'b0;
      cyc(3);
      aresetn <= 1'b1;
      rd(CTRL_ADDR, 32'h0, RESP_OKAY);
      rd(FLAG_ADDR, 32'h20, RESP_OKAY);
      finish_test();
   end
endmodule
